// File: verilog/tmr_pkg.sv
// package: register map, mode codes and field layouts of the triple-mode timer
package tmr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_COUNT    = 12'h004;
  localparam logic [11:0] ADDR_RELOAD_A = 12'h008;
  localparam logic [11:0] ADDR_RELOAD_B = 12'h00C;

  // control word bit positions
  localparam int CTRL_IRQ_EN_B = 0;
  localparam int CTRL_PEND_B   = 1;
  localparam int CTRL_IRQ_EN_A = 2;
  localparam int CTRL_PEND_A   = 3;
  localparam int CTRL_RUN      = 4;
  localparam int CTRL_MODE_LO  = 5;
  localparam int CTRL_MODE_HI  = 7;

  // ----------------------------------------------------------------
  // reset values and the all-ones wrap value
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [2:0]  MODE_RST   = 3'h0;
  localparam logic [15:0] COUNT_ONES = 16'hFFFF;

  // mode field codes
  typedef enum logic [2:0] {
    MODE_EVT_RISE  = 3'b000,
    MODE_EVT_FALL  = 3'b001,
    MODE_CAP_RR    = 3'b010,
    MODE_CAP_FF_LO = 3'b011,
    MODE_PWM_PLAIN = 3'b100,
    MODE_PWM_TOG   = 3'b101,
    MODE_CAP_RF    = 3'b110,
    MODE_CAP_FF    = 3'b111
  } mode_e;

  // software-visible control bits
  typedef struct packed {
    logic [2:0] mode;
    logic       run_or_underflow_flag;
    logic       pend_a;
    logic       irq_en_a;
    logic       pend_b;
    logic       irq_en_b;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{mode: MODE_RST, default: 1'b0};

endpackage

// File: verilog/triple_mode_timer_block.sv
// triple-mode 16-bit timer: pwm, external event counter, dual input capture
// Operation
// - event-counter mode clocks the timer from pin A edges, not the tick
// - mode field picks rising or falling pin A edges for event counting
// - event-counter underflow sets pending A; interrupt when enable A set
// - event-counter mode: rising pin B edge sets pending B, gated by enable B
// - no pwm waveform driven on pin A in event-counter mode
// - capture mode: timer counts continuously at the instruction-cycle tick
// - capture mode: pin A trigger loads capture A, pin B loads capture B
// - capture edge polarity selectable for pins A and B, every pair except A fall with B rise
// - codes 010 rise/rise, 110 rise/fall, 111 and 011 fall/fall
// - capture triggers set pending A and B, gated by enables A and B
// - capture-mode underflow sets the run bit as underflow flag, enable A gates
// - in pwm and event modes run bit 1 starts, 0 stops the timer
// - each interrupt enable permits its interrupt at 1, suppresses at 0
// - code 101 pwm with pin A toggle, 100 without; irq follows reload source
// - pwm counts down on the tick; first reload from A, then B, A, ...
// - pwm underflows alternately set pending A (reload A) and pending B
`timescale 1ns/10ps
`default_nettype none

module triple_mode_timer_block
  import tmr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RST,
  input  wire logic              CE,
  input  wire logic              INSTR_CYCLE_TICK,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              TIMER_PIN_A_I,
  output logic                   TIMER_PIN_A_O,
  output logic                   TIMER_PIN_A_OE,
  input  wire logic              TIMER_PIN_B,
  output logic                   IRQ_A,
  output logic                   IRQ_B
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic is_capture(input logic [2:0] m);
    return (m == MODE_CAP_RR) || (m == MODE_CAP_FF_LO) || (m == MODE_CAP_RF) ||
           (m == MODE_CAP_FF);
  endfunction

  function automatic logic is_pwm(input logic [2:0] m);
    return (m == MODE_PWM_PLAIN) || (m == MODE_PWM_TOG);
  endfunction

  function automatic logic is_event(input logic [2:0] m);
    return (m == MODE_EVT_RISE) || (m == MODE_EVT_FALL);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] pin_in;
  logic [1:0] rise;
  logic [1:0] fall;

  assign pin_in = {TIMER_PIN_B, TIMER_PIN_A_I};

  // index 0 is pin A, index 1 is pin B; both get the same two-stage chain
  for (genvar p = 0; p < 2; p++) begin : g_pin
    logic sync1_q;
    logic sync1_d;
    logic sync2_q;
    logic sync2_d;
    logic prev_q;
    logic prev_d;

    always_comb begin
      sync1_d = pin_in[p];
      sync2_d = sync1_q;
      prev_d  = sync2_q;
    end

    // reset level matches the idle pin level, so no false edge follows reset
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        sync1_q <= 1'b0;
        sync2_q <= 1'b0;
        prev_q  <= 1'b0;
      end else if (CE) begin
        sync1_q <= sync1_d;
        sync2_q <= sync2_d;
        prev_q  <= prev_d;
      end
    end

    // edges come from the second stage only; one clock pulse per edge
    assign rise[p] = sync2_q & ~prev_q;
    assign fall[p] = ~sync2_q & prev_q;
  end

  // ----------------------------------------------------------------
  // timer, reload/capture registers and control bits
  // ----------------------------------------------------------------
  ctrl_s       ctrl_q, ctrl_d;
  logic [15:0] count_q, count_d;
  logic [15:0] reload_capture_a_q, reload_capture_a_d;
  logic [15:0] reload_capture_b_q, reload_capture_b_d;
  logic        next_b_q, next_b_d;
  logic        pin_a_q, pin_a_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pin_a_oe_q, pin_a_oe_d;
  logic        irq_a_q, irq_a_d;
  logic        irq_b_q, irq_b_d;

  ctrl_s       wr_ctrl;
  logic        wr_acc;
  logic        rd_setup;
  logic        step;
  logic        underflow;
  logic        trig_a;
  logic        trig_b;
  logic [2:0]  mode;

  assign mode     = ctrl_q.mode;
  assign wr_ctrl  = ctrl_s'(PWDATA[CTRL_MODE_HI:CTRL_IRQ_EN_B]);
  assign wr_acc   = PSEL && PENABLE && PWRITE;
  // read data is latched in the setup cycle, so it stands through the access edge
  assign rd_setup = PSEL && !PENABLE && !PWRITE;

  // ----------------------------------------------------------------
  // step and trigger decode
  // ----------------------------------------------------------------
  // pwm and capture step on the tick; the event counter steps on pin A edges
  always_comb begin
    step = 1'b0;
    if (is_capture(mode)) begin
      step = INSTR_CYCLE_TICK;
    end else if (is_pwm(mode)) begin
      step = INSTR_CYCLE_TICK && ctrl_q.run_or_underflow_flag;
    end else if (is_event(mode)) begin
      step = ctrl_q.run_or_underflow_flag &&
             ((mode == MODE_EVT_FALL) ? fall[0] : rise[0]);
    end
  end

  assign underflow = step && (count_q == COUNT_RST);

  // capture trigger polarity: A falls for 011/111, B falls for 110/011/111
  always_comb begin
    trig_a = is_capture(mode) && (mode[0] ? fall[0] : rise[0]);
    trig_b = is_capture(mode) && ((mode[2] || mode[0]) ? fall[1] : rise[1]);
  end

  // ----------------------------------------------------------------
  // next state of control, count and reload/capture registers
  // ----------------------------------------------------------------
  // a count write in the same cycle as a step is lost; the step wins
  always_comb begin
    ctrl_d             = ctrl_q;
    count_d            = count_q;
    reload_capture_a_d = reload_capture_a_q;
    reload_capture_b_d = reload_capture_b_q;
    next_b_d           = next_b_q;
    pin_a_d            = pin_a_q;

    // software writes first, so hardware sets below win over a clear
    if (wr_acc) begin
      case (PADDR)
        ADDR_CTRL: begin
          ctrl_d = wr_ctrl;
          // entering pwm from another mode restarts the reload order with A
          if (is_pwm(wr_ctrl.mode) && !is_pwm(mode)) begin
            next_b_d = 1'b0;
          end
        end
        ADDR_COUNT:    count_d            = PWDATA[15:0];
        ADDR_RELOAD_A: reload_capture_a_d = PWDATA[15:0];
        ADDR_RELOAD_B: reload_capture_b_d = PWDATA[15:0];
        default: ;
      endcase
    end

    if (step) begin
      count_d = count_q - 16'h0001;
    end

    if (underflow) begin
      if (is_pwm(mode)) begin
        count_d  = next_b_q ? reload_capture_b_q : reload_capture_a_q;
        next_b_d = ~next_b_q;
        if (next_b_q) begin
          ctrl_d.pend_b = 1'b1;
        end else begin
          ctrl_d.pend_a = 1'b1;
        end
        if (mode == MODE_PWM_TOG) begin
          pin_a_d = ~pin_a_q;
        end
      end else if (is_event(mode)) begin
        // the event counter reloads from A, so it divides the pin rate
        count_d       = reload_capture_a_q;
        ctrl_d.pend_a = 1'b1;
      end else begin
        count_d                      = COUNT_ONES;
        ctrl_d.run_or_underflow_flag = 1'b1;
      end
    end

    if (is_event(mode) && rise[1]) begin
      ctrl_d.pend_b = 1'b1;
    end

    if (trig_a) begin
      reload_capture_a_d = count_q;
      ctrl_d.pend_a      = 1'b1;
    end
    if (trig_b) begin
      reload_capture_b_d = count_q;
      ctrl_d.pend_b      = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // apb read path: zero wait states, unmapped reads as zero
  // ----------------------------------------------------------------
  always_comb begin
    prdata_d = prdata_q;
    if (rd_setup) begin
      case (PADDR)
        ADDR_CTRL:     prdata_d = {24'h000000, ctrl_q};
        ADDR_COUNT:    prdata_d = {16'h0000, count_q};
        ADDR_RELOAD_A: prdata_d = {16'h0000, reload_capture_a_q};
        ADDR_RELOAD_B: prdata_d = {16'h0000, reload_capture_b_q};
        default:       prdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_q             <= CTRL_RST;
      count_q            <= COUNT_RST;
      reload_capture_a_q <= RELOAD_RST;
      reload_capture_b_q <= RELOAD_RST;
      next_b_q           <= 1'b0;
      pin_a_q            <= 1'b0;
      prdata_q           <= 32'h00000000;
    end else if (CE) begin
      ctrl_q             <= ctrl_d;
      count_q            <= count_d;
      reload_capture_a_q <= reload_capture_a_d;
      reload_capture_b_q <= reload_capture_b_d;
      next_b_q           <= next_b_d;
      pin_a_q            <= pin_a_d;
      prdata_q           <= prdata_d;
    end
  end

  // ----------------------------------------------------------------
  // registered pin enable and interrupt outputs
  // ----------------------------------------------------------------
  // built from the next control state, so they change on the same edge as the bits
  always_comb begin
    // pin A is driven only in pwm modes; elsewhere it is the counter/capture input
    pin_a_oe_d = is_pwm(ctrl_d.mode);
    // capture mode: the underflow flag shares interrupt A
    irq_a_d    = ctrl_d.irq_en_a && (ctrl_d.pend_a ||
                 (is_capture(ctrl_d.mode) && ctrl_d.run_or_underflow_flag));
    irq_b_d    = ctrl_d.irq_en_b && ctrl_d.pend_b;
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_a_oe_q <= 1'b0;
      irq_a_q    <= 1'b0;
      irq_b_q    <= 1'b0;
    end else if (CE) begin
      pin_a_oe_q <= pin_a_oe_d;
      irq_a_q    <= irq_a_d;
      irq_b_q    <= irq_b_d;
    end
  end

  // pready stays high while ce is low, so the bus must stay idle then
  assign PRDATA         = prdata_q;
  assign PREADY         = 1'b1;
  assign PSLVERR        = 1'b0;
  assign TIMER_PIN_A_O  = pin_a_q;
  assign TIMER_PIN_A_OE = pin_a_oe_q;
  assign IRQ_A          = irq_a_q;
  assign IRQ_B          = irq_b_q;

endmodule

`default_nettype wire

// File: dv/tmr_pins.sv
// partner model: external signal source on timer pins A and B
`timescale 1ns/10ps
`default_nettype none

module tmr_pins (
  input  wire logic clk,
  output logic      pin_a,
  output logic      pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // levels change just after an edge; the hold covers the sync chain and flag update
  task automatic drive(input bit sel_b, input logic lvl, input int hold = 6);
    @(posedge clk);
    if (sel_b) begin
      pin_b <= lvl;
    end else begin
      pin_a <= lvl;
    end
    repeat (hold) @(posedge clk);
    #1;
  endtask
endmodule

`default_nettype wire

// File: dv/tmr_chk.sv
// checker: port-level assertions for the triple-mode timer
`timescale 1ns/10ps
`default_nettype none

module tmr_chk
  import tmr_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        CE,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        TIMER_PIN_A_I,
  input wire logic        TIMER_PIN_A_OE,
  input wire logic        TIMER_PIN_B,
  input wire logic        IRQ_A,
  input wire logic        IRQ_B
);
  // shadow of mode and enables; only software ever changes these bits
  logic [7:0] sw_q;
  logic [7:0] sw_d;
  logic       wr;
  assign wr = CE & PSEL & PENABLE & PWRITE & (PADDR == ADDR_CTRL);
  always_comb sw_d = wr ? PWDATA[7:0] : sw_q;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) sw_q <= 8'h00;
    else sw_q <= sw_d;
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_irq_a_gate: assert property (!sw_q[2] |-> !IRQ_A)
    else $error("irq a raised while disabled");
  a_irq_b_gate: assert property (!sw_q[0] |-> !IRQ_B)
    else $error("irq b raised while disabled");
  a_evt_pin_b: assert property (
    sw_q[7:6] == 2'b00 && sw_q[0] && $rose(TIMER_PIN_B) |-> ##[1:5] IRQ_B)
    else $error("pin b rise did not raise irq b");
  a_evt_no_drive: assert property (sw_q[7:6] == 2'b00 |-> !TIMER_PIN_A_OE)
    else $error("pin a driven in event mode");
  a_pwm_drive: assert property (sw_q[7:6] == 2'b10 |-> TIMER_PIN_A_OE)
    else $error("pin a not driven in pwm mode");
  a_cap_a_edge: assert property (
    sw_q[6] && sw_q[2] && (sw_q[5] ? $fell(TIMER_PIN_A_I) : $rose(TIMER_PIN_A_I))
    |-> ##[1:5] IRQ_A)
    else $error("pin a capture edge missed");
  a_cap_b_edge: assert property (
    sw_q[6] && sw_q[0] &&
    (sw_q[7:5] == MODE_CAP_RR ? $rose(TIMER_PIN_B) : $fell(TIMER_PIN_B))
    |-> ##[1:5] IRQ_B)
    else $error("pin b capture edge missed");
  a_irq_a_holds: assert property (IRQ_A && !wr |=> IRQ_A)
    else $error("irq a dropped without software");
  a_irq_b_holds: assert property (IRQ_B && !wr |=> IRQ_B)
    else $error("irq b dropped without software");

  c_pwm_irq: cover property (sw_q[7:6] == 2'b10 && IRQ_B);
  c_evt_irq: cover property (sw_q[7:6] == 2'b00 && IRQ_A);
  c_cap_irq: cover property (sw_q[6] && IRQ_B);
endmodule

bind triple_mode_timer_block tmr_chk u_chk (.CLK_SYS, .RST, .CE, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .TIMER_PIN_A_I, .TIMER_PIN_A_OE, .TIMER_PIN_B, .IRQ_A, .IRQ_B);

`default_nettype wire

// File: dv/triple_mode_timer_block_test.sv
// testbench: self-checking scenarios for the triple-mode timer
`timescale 1ns/10ps
`default_nettype none

module triple_mode_timer_block_test
  import tmr_pkg::*;
;
  logic        CLK_SYS, RST, CE, PSEL, PENABLE, PWRITE, TICK, PREADY, PSLVERR;
  logic        PIN_A, PIN_B, PIN_A_O, PIN_A_OE, IRQ_A, IRQ_B;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  int          fail_count, samples_checked;

  tmr_pins u_pins (.clk(CLK_SYS), .pin_a(PIN_A), .pin_b(PIN_B));
  triple_mode_timer_block dut (.CLK_SYS, .RST, .CE, .INSTR_CYCLE_TICK(TICK),
    .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .TIMER_PIN_A_I(PIN_A), .TIMER_PIN_A_O(PIN_A_O), .TIMER_PIN_A_OE(PIN_A_OE),
    .TIMER_PIN_B(PIN_B), .IRQ_A, .IRQ_B);

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // master holds the whole request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      finish_test();
    end else begin
      rd = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      #1;
    end
  endtask

  task automatic rdc(input logic [11:0] a, input string n, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge CLK_SYS);
      TICK <= 1'b1;
      @(posedge CLK_SYS);
      TICK <= 1'b0;
    end
    #1;
  endtask

  task automatic t_reset;
    apb(1'b1, 12'h010, 32'hFFFF);
    for (int i = 0; i < 5; i++) begin
      rdc(12'(i * 4), "reset read", 32'h0);
    end
    chk("slverr", 32'h0, PSLVERR);
    $display("reset test done");
  endtask

  task automatic t_evt;
    apb(1'b1, ADDR_RELOAD_A, 32'h2);
    apb(1'b1, ADDR_COUNT, 32'h2);
    apb(1'b1, ADDR_CTRL, 32'h15);
    u_pins.drive(0, 1'b1);
    rdc(ADDR_COUNT, "rise counted", 32'h1);
    u_pins.drive(0, 1'b0);
    tick(3);
    rdc(ADDR_COUNT, "fall and tick", 32'h1);
    apb(1'b1, ADDR_COUNT, 32'h0);
    u_pins.drive(0, 1'b1);
    chk("evt irq a", 32'h1, IRQ_A);
    rdc(ADDR_COUNT, "evt reload", 32'h2);
    apb(1'b1, ADDR_CTRL, 32'h35);
    u_pins.drive(0, 1'b0);
    rdc(ADDR_COUNT, "fall counted", 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h25);
    u_pins.drive(0, 1'b1);
    u_pins.drive(0, 1'b0);
    rdc(ADDR_COUNT, "stopped", 32'h1);
    u_pins.drive(1, 1'b1);
    chk("pin b irq", 32'h1, IRQ_B);
    apb(1'b1, ADDR_CTRL, 32'h24);
    u_pins.drive(1, 1'b0);
    u_pins.drive(1, 1'b1);
    chk("irq b masked", 32'h0, IRQ_B);
    rdc(ADDR_CTRL, "pend b set", 32'h26);
    $display("event test done");
  endtask

  task automatic t_cap;
    apb(1'b1, ADDR_CTRL, 32'h45);
    apb(1'b1, ADDR_COUNT, 32'h1234);
    u_pins.drive(0, 1'b1);
    rdc(ADDR_RELOAD_A, "cap a rise", 32'h1234);
    chk("cap irq a", 32'h1, IRQ_A);
    apb(1'b1, ADDR_CTRL, 32'hC5);
    apb(1'b1, ADDR_COUNT, 32'h55);
    u_pins.drive(1, 1'b0);
    rdc(ADDR_RELOAD_B, "cap b fall", 32'h55);
    chk("cap irq b", 32'h1, IRQ_B);
    apb(1'b1, ADDR_CTRL, 32'hE5);
    apb(1'b1, ADDR_COUNT, 32'hAA);
    u_pins.drive(0, 1'b0);
    rdc(ADDR_RELOAD_A, "cap a fall", 32'hAA);
    apb(1'b1, ADDR_CTRL, 32'hE4);
    chk("irq a clear", 32'h0, IRQ_A);
    apb(1'b1, ADDR_COUNT, 32'h0);
    tick(1);
    rdc(ADDR_COUNT, "wrap", 32'hFFFF);
    rdc(ADDR_CTRL, "underflow flag", 32'hF4);
    chk("underflow irq", 32'h1, IRQ_A);
    apb(1'b1, ADDR_CTRL, 32'h65);
    apb(1'b1, ADDR_COUNT, 32'h77);
    u_pins.drive(0, 1'b1);
    chk("no cap on rise", 32'h0, IRQ_A);
    u_pins.drive(0, 1'b0);
    rdc(ADDR_RELOAD_A, "cap a fall 011", 32'h77);
    chk("cap irq a 011", 32'h1, IRQ_A);
    $display("capture test done");
  endtask

  task automatic t_pwm;
    logic o;
    apb(1'b1, ADDR_RELOAD_A, 32'h3);
    apb(1'b1, ADDR_RELOAD_B, 32'h5);
    apb(1'b1, ADDR_COUNT, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'hB5);
    chk("pwm drive", 32'h1, PIN_A_OE);
    o = PIN_A_O;
    tick(1);
    chk("first irq a", 32'h1, IRQ_A);
    chk("first irq b", 32'h0, IRQ_B);
    rdc(ADDR_COUNT, "reload a", 32'h3);
    chk("toggle 1", {31'h0, ~o}, PIN_A_O);
    tick(4);
    chk("second irq b", 32'h1, IRQ_B);
    rdc(ADDR_COUNT, "reload b", 32'h5);
    chk("toggle 2", {31'h0, o}, PIN_A_O);
    apb(1'b1, ADDR_CTRL, 32'h95);
    tick(6);
    chk("plain irq a", 32'h1, IRQ_A);
    rdc(ADDR_COUNT, "plain reload a", 32'h3);
    chk("no toggle", {31'h0, o}, PIN_A_O);
    $display("pwm test done");
  endtask

  // clock enable low freezes all state; then a reset in mid-run clears it
  task automatic t_hold;
    @(posedge CLK_SYS);
    CE <= 1'b0;
    tick(3);
    @(posedge CLK_SYS);
    CE <= 1'b1;
    rdc(ADDR_COUNT, "frozen count", 32'h3);
    chk("frozen irq a", 32'h1, IRQ_A);
    tick(1);
    rdc(ADDR_COUNT, "count resumes", 32'h2);
    @(posedge CLK_SYS);
    RST <= 1'b1;
    @(posedge CLK_SYS);
    #1;
    chk("reset prdata", 32'h0, PRDATA);
    chk("reset outputs", 32'h0, {PIN_A_O, PIN_A_OE, IRQ_A, IRQ_B});
    @(posedge CLK_SYS);
    RST <= 1'b0;
    rdc(ADDR_CTRL, "reset ctrl", 32'h0);
    rdc(ADDR_COUNT, "reset count", 32'h0);
    $display("hold and reset test done");
  endtask

  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end

  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    TICK = 1'b0;
    CE = 1'b1;
    fail_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge CLK_SYS);
    RST <= 1'b0;
    t_reset();
    t_evt();
    t_cap();
    t_pwm();
    t_hold();
    finish_test();
  end
endmodule

`default_nettype wire
